//--- include/occ_consts.svh
// Purpose: Shared constants of the oscillator control block.
// Assumes: A 40 MHz ref_clk; 12-bit register addresses.
// Notes:   Definitions only.
`ifndef OCC_CONSTS_SVH
`define OCC_CONSTS_SVH

// Register addresses on the plain register port.
`define OCC_CTL_ADDR     12'hF86
`define OCC_STAT_ADDR    12'hF87
`define OCC_MASK_ADDR    12'hF88

// Unlock values, first then second.
`define OCC_UNLOCK_FIRST  8'hE7
`define OCC_UNLOCK_SECOND 8'h18

// Control register reset value with the crystal enable bit cleared.
`define OCC_CTL_RESET    8'hA0
`define OCC_XTAL_BIT     6

// Source select codes.
`define OCC_SEL_IPO_FAST 3'h0
`define OCC_SEL_IPO_SLOW 3'h1
`define OCC_SEL_XTAL     3'h2
`define OCC_SEL_WDT      3'h3
`define OCC_SEL_EXT      3'h4
`define OCC_SEL_LAST     3'h4

// Status and mask bit positions.
`define OCC_ST_SYSFAIL   0
`define OCC_ST_WDTFAIL   1
`define OCC_ST_WIDTH     2

// Timing: clock period and failure thresholds.
`define OCC_CLK_PERIOD_NS 25
`define OCC_SYSFAIL_NS    1000000
`define OCC_WDTFAIL_CYC   8004

`endif

//--- include/occ_pkg.sv
// Purpose: Types of the oscillator control block.
// Assumes: Nothing beyond the constants header.
// Notes:   Field order follows the control register bit order.
package occ_pkg;

  // Control register fields, bit 7 first.
  typedef struct packed {
    logic       precision_osc_enable;
    logic       crystal_osc_enable;
    logic       watchdog_osc_enable;
    logic       sysclk_fail_detect_enable;
    logic       watchdog_osc_fail_detect_enable;
    logic [2:0] sysclk_source_select;
  } occ_ctl_type;

  // Nonvolatile option bits seen by the block.
  typedef struct packed {
    logic       crystal_reset_disable_option;
    logic [1:0] crystal_drive_mode;
  } occ_option_type;

  // Progress of the unlock sequence.
  typedef enum {OCC_LOCKED, OCC_FIRST_SEEN, OCC_OPEN} occ_lock_type;

endpackage : occ_pkg

//--- hw/occ_edge_watch.sv
// Purpose: Watches a foreign clock for edges and flags a stall.
// Assumes: raw_in is asynchronous to ref_clk.
// Notes:   The flag is sticky while enable stays high.
`timescale 1ns/10ps
`default_nettype none
`include "occ_consts.svh"
module occ_edge_watch #(
  parameter int LIMIT = `OCC_WDTFAIL_CYC
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic enable,
  input  wire logic raw_in,
  output logic      fail
);
  import occ_pkg::*;

  localparam int CW = $clog2(LIMIT + 1);

  // A limit below two leaves no room to see an edge.
  if (LIMIT < 2) begin : g_bad_limit
    $error("occ_edge_watch: LIMIT must be at least 2");
  end

  logic [2:0]    sync_reg;   // Three-stage synchroniser.
  logic          stable_reg; // Last agreed level.
  logic [CW-1:0] count_reg;  // Cycles since the last edge.
  logic          fail_reg;   // Stall flag.
  logic          edge_seen;  // Agreed change this cycle.

  // A change counts once the second and third stages agree.
  assign edge_seen = (sync_reg[1] == sync_reg[2]) && (sync_reg[2] != stable_reg);
  assign fail      = fail_reg;

  // Synchroniser chain.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_reg   <= 3'h0;
      stable_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], raw_in};
      if (sync_reg[1] == sync_reg[2]) begin
        stable_reg <= sync_reg[2];
      end
    end
  end

  // Counts cycles without an edge and flags the stall.
  always_ff @(posedge ref_clk) begin
    if (reset || !enable || edge_seen) begin
      count_reg <= '0;
      fail_reg  <= fail_reg && enable && !reset;
    end else if (count_reg == CW'(LIMIT - 1)) begin
      fail_reg <= 1'b1;
    end else begin
      count_reg <= count_reg + CW'(1);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // The flag rises only after the full count without an edge.
  chk_stall_count: assert property ($rose(fail_reg) |->
    $past(count_reg) == CW'(LIMIT - 1) && $past(enable))
    else $error("stall flagged before full count");

endmodule : occ_edge_watch
`default_nettype wire

//--- hw/occ_oscillator_control.sv
// Purpose: Lockable oscillator control register with failure handling.
// Assumes: ref_clk is the system clock; sysclk_osc_in and watchdog_osc_in
//          are the running oscillators, asynchronous to ref_clk.
// Notes:   The glitch-free clock mux sits outside; it follows the select.
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "occ_consts.svh"

// Functional notes
// - Change needs first then second unlock value.
// - Register relocks after each successful write.
// - Other write orders have no effect.
// - Bit 7 enables the precision oscillator.
// - Bit 6 enables crystal, overriding pin settings.
// - Bit 5 enables the watchdog oscillator.
// - Bit 4 enables clock failure detect, recovery.
// - Bit 3 enables watchdog oscillator failure detect.
// - Three-bit field selects system clock source.
// - Option bit sets crystal enable at reset.
// - Crystal may stop once another source selected.
// - System clock is undivided selected oscillator.
// - Crystal drive mode comes from option bits.
// - Clock failure forces watchdog clock, raises event; the code forces it only while bit 5 is set.
// - Watchdog failure after 8004 edgeless cycles.
module occ_oscillator_control #(
  parameter int SYSFAIL_CYCLES = `OCC_SYSFAIL_NS / `OCC_CLK_PERIOD_NS,
  parameter int WDTFAIL_CYCLES = `OCC_WDTFAIL_CYC
) (
  input  wire logic            ref_clk,
  input  wire logic            reset,
  input  wire logic [11:0]     reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [7:0]           reg_rdata,
  input  wire occ_pkg::occ_option_type option_bits,
  input  wire logic            sysclk_osc_in,
  input  wire logic            watchdog_osc_in,
  output logic                 precision_osc_enable,
  output logic                 crystal_osc_enable,
  output logic                 crystal_pin_override,
  output logic                 watchdog_osc_enable,
  output logic [2:0]           sysclk_source_select,
  output logic [1:0]           crystal_drive_mode,
  output logic                 sysclk_fail_event,
  output logic                 watchdog_fail_event,
  output logic                 irq
);
  import occ_pkg::*;

  // Thresholds that the counters cannot serve are refused.
  if (SYSFAIL_CYCLES < 2 || WDTFAIL_CYCLES < 2) begin : g_bad_param
    $error("occ_oscillator_control: failure counts must be at least 2");
  end

  occ_ctl_type  ctl_reg;        // Control register.
  occ_ctl_type  ctl_next;       // Value an open write would store.
  occ_lock_type lock_reg;       // Unlock sequence progress.
  logic         force_reg;      // Recovery holds the watchdog clock.
  logic         wdt_dead_reg;   // Watchdog oscillator declared failed.
  logic [2:0]   sel_out_reg;    // Effective source select.
  logic [1:0]   drive_reg;      // Crystal drive mode.
  logic         sys_ev_reg;     // Clock failure event pulse.
  logic         wdt_ev_reg;     // Watchdog failure event pulse.
  logic [`OCC_ST_WIDTH-1:0] status_reg; // Sticky event bits.
  logic [`OCC_ST_WIDTH-1:0] mask_reg;   // Interrupt mask.
  logic [7:0]   rdata_reg;      // Read data, one cycle after strobe.
  logic         irq_reg;        // Interrupt output register.
  logic         sys_fail;       // Clock stall from the monitor.
  logic         wdt_fail;       // Watchdog stall from the monitor.
  logic         sys_fail_d;     // Clock stall, one cycle old.
  logic         wdt_fail_d;     // Watchdog stall, one cycle old.
  logic         sys_mon_en;     // Clock monitor active.
  logic         wdt_mon_en;     // Watchdog monitor active.
  logic         ctl_wr;         // Write to the control address.
  logic         ctl_wr_open;    // Write that changes the register.
  logic         sys_rise;       // New clock failure.
  logic         wdt_rise;       // New watchdog failure.

  // Decoded write strobes and new failure edges.
  assign ctl_wr      = reg_wr && (reg_addr == `OCC_CTL_ADDR);
  assign ctl_wr_open = ctl_wr && (lock_reg == OCC_OPEN);
  assign sys_rise    = sys_fail && !sys_fail_d;
  assign wdt_rise    = wdt_fail && !wdt_fail_d;

  // Clock monitor runs only with detection on and no watchdog clock.
  assign sys_mon_en = ctl_reg.sysclk_fail_detect_enable && !wdt_dead_reg &&
                      !force_reg && (ctl_reg.sysclk_source_select != `OCC_SEL_WDT);
  // Watchdog monitor needs a running, unselected watchdog oscillator.
  assign wdt_mon_en = ctl_reg.watchdog_osc_fail_detect_enable &&
                      ctl_reg.watchdog_osc_enable && !force_reg &&
                      (ctl_reg.sysclk_source_select != `OCC_SEL_WDT);

  // Outputs straight from registers.
  assign precision_osc_enable = ctl_reg.precision_osc_enable;
  assign crystal_osc_enable   = ctl_reg.crystal_osc_enable;
  assign crystal_pin_override = ctl_reg.crystal_osc_enable;
  assign watchdog_osc_enable  = ctl_reg.watchdog_osc_enable;
  assign sysclk_source_select = sel_out_reg;
  assign crystal_drive_mode   = drive_reg;
  assign sysclk_fail_event    = sys_ev_reg;
  assign watchdog_fail_event  = wdt_ev_reg;
  assign reg_rdata            = rdata_reg;
  assign irq                  = irq_reg;

  // Value stored by an open write, after the select and crystal guards.
  always_comb begin
    ctl_next = occ_ctl_type'(reg_wdata);
    // Reserved codes leave the source where it is.
    if (reg_wdata[2:0] > `OCC_SEL_LAST) begin
      ctl_next.sysclk_source_select = ctl_reg.sysclk_source_select;
    end
    // The crystal stays on while it would still drive the clock.
    if (ctl_next.sysclk_source_select == `OCC_SEL_XTAL) begin
      ctl_next.crystal_osc_enable = reg_wdata[`OCC_XTAL_BIT] ||
                                    ctl_reg.crystal_osc_enable;
    end
  end

  // Unlock sequence: first value, then second, then one open write.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lock_reg <= OCC_LOCKED;
    end else if (ctl_wr) begin
      unique case (lock_reg)
        OCC_LOCKED: begin
          // Only the first value advances.
          if (reg_wdata == `OCC_UNLOCK_FIRST) begin
            lock_reg <= OCC_FIRST_SEEN;
          end
        end
        OCC_FIRST_SEEN: begin
          // The second value opens; a repeated first keeps the step.
          if (reg_wdata == `OCC_UNLOCK_SECOND) begin
            lock_reg <= OCC_OPEN;
          end else if (reg_wdata != `OCC_UNLOCK_FIRST) begin
            lock_reg <= OCC_LOCKED;
          end
        end
        OCC_OPEN: begin
          // The write lands and the register locks again.
          lock_reg <= OCC_LOCKED;
        end
      endcase
    end
  end

  // Control register; the crystal bit follows the option at reset.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctl_reg <= occ_ctl_type'(`OCC_CTL_RESET);
      ctl_reg.crystal_osc_enable <= !option_bits.crystal_reset_disable_option;
    end else if (ctl_wr_open) begin
      ctl_reg <= ctl_next;
    end
  end

  // Effective select; recovery overrides the stored field.
  // The selected oscillator drives the clock as is, with no divider.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sel_out_reg <= `OCC_SEL_IPO_FAST;
    end else if (force_reg) begin
      sel_out_reg <= `OCC_SEL_WDT;
    end else begin
      sel_out_reg <= ctl_reg.sysclk_source_select;
    end
  end

  // Drive mode follows the option bits only, in reset too, so it is never stale.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      drive_reg <= option_bits.crystal_drive_mode;
    end else begin
      drive_reg <= option_bits.crystal_drive_mode;
    end
  end

  // Recovery latch; a new open write hands the clock back to software.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      force_reg <= 1'b0;
    end else if (sys_rise && ctl_reg.watchdog_osc_enable) begin
      force_reg <= 1'b1;
    end else if (ctl_wr_open) begin
      force_reg <= 1'b0;
    end
  end

  // Watchdog failure memory, cleared with its detection enable.
  always_ff @(posedge ref_clk) begin
    if (reset || !ctl_reg.watchdog_osc_fail_detect_enable) begin
      wdt_dead_reg <= 1'b0;
    end else if (wdt_rise) begin
      wdt_dead_reg <= 1'b1;
    end
  end

  // Failure event pulses, one cycle each.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sys_fail_d <= 1'b0;
      wdt_fail_d <= 1'b0;
      sys_ev_reg <= 1'b0;
      wdt_ev_reg <= 1'b0;
    end else begin
      sys_fail_d <= sys_fail;
      wdt_fail_d <= wdt_fail;
      sys_ev_reg <= sys_rise;
      wdt_ev_reg <= wdt_rise;
    end
  end

  // Sticky status; a new event wins over a write-one clear.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_reg <= '0;
    end else begin
      if (reg_wr && (reg_addr == `OCC_STAT_ADDR)) begin
        status_reg <= status_reg & ~reg_wdata[`OCC_ST_WIDTH-1:0];
      end
      if (sys_rise) begin
        status_reg[`OCC_ST_SYSFAIL] <= 1'b1;
      end
      if (wdt_rise) begin
        status_reg[`OCC_ST_WDTFAIL] <= 1'b1;
      end
    end
  end

  // Interrupt mask register.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask_reg <= '0;
    end else if (reg_wr && (reg_addr == `OCC_MASK_ADDR)) begin
      mask_reg <= reg_wdata[`OCC_ST_WIDTH-1:0];
    end
  end

  // Level interrupt while any unmasked status bit is set.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // Read data stand for the one cycle after the strobe; else zero.
  always_ff @(posedge ref_clk) begin
    if (reset || !reg_rd) begin
      rdata_reg <= 8'h00;
    end else begin
      unique case (reg_addr)
        `OCC_CTL_ADDR:  rdata_reg <= ctl_reg;
        `OCC_STAT_ADDR: rdata_reg <= {6'h00, status_reg};
        `OCC_MASK_ADDR: rdata_reg <= {6'h00, mask_reg};
        default:        rdata_reg <= 8'h00;
      endcase
    end
  end

  // Stall monitor of the selected system oscillator.
  occ_edge_watch #(
    .LIMIT   (SYSFAIL_CYCLES)
  ) u_sys_watch (
    .ref_clk (ref_clk),
    .reset   (reset),
    .enable  (sys_mon_en),
    .raw_in  (sysclk_osc_in),
    .fail    (sys_fail)
  );

  // Stall monitor of the watchdog oscillator.
  occ_edge_watch #(
    .LIMIT   (WDTFAIL_CYCLES)
  ) u_wdt_watch (
    .ref_clk (ref_clk),
    .reset   (reset),
    .enable  (wdt_mon_en),
    .raw_in  (watchdog_osc_in),
    .fail    (wdt_fail)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Full unlock: first value, second value, then the data write.
  sequence s_unlock_first;
    ctl_wr && lock_reg == OCC_LOCKED && reg_wdata == `OCC_UNLOCK_FIRST;
  endsequence
  sequence s_unlock_done;
    lock_reg == OCC_OPEN;
  endsequence

  // The register changes only through an open write.
  chk_change_unlocked: assert property ($changed(ctl_reg) |->
    $past(ctl_wr_open))
    else $error("control changed without unlock");

  // The first unlock value arms the sequence for the second.
  chk_first_step: assert property (s_unlock_first |=>
    lock_reg == OCC_FIRST_SEEN)
    else $error("first unlock value not taken");

  // An open write locks the register again.
  chk_relock: assert property (s_unlock_done ##0 ctl_wr |=>
    lock_reg == OCC_LOCKED)
    else $error("register stayed open after write");

  // A stray value while locked changes nothing.
  chk_stray_write: assert property (ctl_wr && lock_reg == OCC_LOCKED &&
    reg_wdata != `OCC_UNLOCK_FIRST |=> lock_reg == OCC_LOCKED && $stable(ctl_reg))
    else $error("stray write had an effect");

  // Precision and watchdog enable bits appear at the outputs after an open write.
  chk_enable_bits: assert property (ctl_wr_open |=>
    precision_osc_enable == $past(reg_wdata[7]) &&
    watchdog_osc_enable == $past(reg_wdata[5]) &&
    crystal_pin_override == crystal_osc_enable)
    else $error("enable bits not stored");

  // A legal code reaches the select output two cycles on.
  chk_select_code: assert property (ctl_wr_open && reg_wdata[2:0] <= `OCC_SEL_LAST &&
    !force_reg && !sys_rise ##1 1 |=> sysclk_source_select == $past(reg_wdata[2:0], 2))
    else $error("select code not applied");

  // A reserved code keeps the source.
  chk_reserved_sel: assert property (ctl_wr_open && reg_wdata[2:0] > `OCC_SEL_LAST |=>
    $stable(ctl_reg.sysclk_source_select))
    else $error("reserved select code applied");

  // Crystal enable after reset follows the option bit.
  chk_crystal_reset: assert property ($fell(reset) |->
    crystal_osc_enable == !$past(option_bits.crystal_reset_disable_option))
    else $error("crystal reset enable wrong");

  // The crystal never stops while it is the stored source.
  chk_crystal_kept: assert property ($fell(crystal_osc_enable) |->
    ctl_reg.sysclk_source_select != `OCC_SEL_XTAL)
    else $error("crystal stopped while selected");

  // Drive mode tracks the option bits one cycle later.
  chk_drive_mode: assert property (##1 crystal_drive_mode ==
    $past(option_bits.crystal_drive_mode))
    else $error("drive mode not from option bits");

  // Recovery forces the watchdog clock within two cycles.
  chk_recovery: assert property (sys_rise && ctl_reg.watchdog_osc_enable |=>
    sysclk_fail_event ##1 sysclk_source_select == `OCC_SEL_WDT)
    else $error("clock failure not recovered");

  // A watchdog failure never switches the clock.
  chk_wdt_no_switch: assert property (wdt_rise && !sys_rise |=>
    watchdog_fail_event && $stable(force_reg))
    else $error("watchdog failure switched clock");

  // Interrupt follows unmasked status one cycle later.
  chk_irq_level: assert property (##1 irq == $past(|(status_reg & mask_reg)))
    else $error("interrupt level wrong");

endmodule : occ_oscillator_control
`default_nettype wire

//--- verification/occ_osc_model.sv
// Purpose: Behavioural model of the two oscillators that feed the block.
// Assumes: The bench stops an oscillator to fake a failure of it.
// Notes:   Both run free and are unrelated in phase to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module occ_osc_model #(
  parameter int SYS_HALF_NS = 160,
  parameter int WDT_HALF_NS = 190
) (
  input  wire logic run_sys,
  input  wire logic run_wdt,
  output logic      sysclk_osc_out,
  output logic      watchdog_osc_out
);
  // Both lines start low; a stopped oscillator holds its last level.
  initial begin
    sysclk_osc_out = 1'h0;
    watchdog_osc_out = 1'h0;
  end

  // The system oscillator toggles at its own rate while it runs.
  always begin
    #(SYS_HALF_NS);
    if (run_sys) begin
      sysclk_osc_out = ~sysclk_osc_out;
    end
  end

  // The watchdog oscillator is slower and has its own phase.
  always begin
    #(WDT_HALF_NS);
    if (run_wdt) begin
      watchdog_osc_out = ~watchdog_osc_out;
    end
  end
endmodule : occ_osc_model
`default_nettype wire

//--- verification/occ_oscillator_control_tb_top.sv
// Purpose: Self-checking bench of the oscillator control block.
// Assumes: Failure limits are shortened to 50 and 40 cycles.
// Notes:   Ordinary control writes run from a table of rows.
`timescale 1ns/10ps
`default_nettype none
`include "occ_consts.svh"
module occ_oscillator_control_tb_top;
  import occ_pkg::*;
  localparam int MAX_CYC = 60000;
  // One row: value written after unlocking, control value expected.
  typedef struct packed {
    logic [7:0] wdata;
    logic [7:0] exp_ctl;
  } occ_row_type;

  logic           ref_clk, reset, reg_wr, reg_rd, run_sys, run_wdt;
  logic [11:0]    reg_addr;
  logic [7:0]     reg_wdata, reg_rdata, rd_val;
  occ_option_type option_bits;
  logic           sys_osc, wdt_osc, precision_osc_enable, crystal_osc_enable;
  logic           crystal_pin_override, watchdog_osc_enable, irq;
  logic           sysclk_fail_event, watchdog_fail_event;
  logic [2:0]     sysclk_source_select;
  logic [1:0]     crystal_drive_mode;
  int             err_total, compares, cyc, sys_ev, wdt_ev, n;
  occ_row_type    rows [0:8] = '{
    '{8'hC0, 8'hC0}, '{8'hE1, 8'hE1}, '{8'hE2, 8'hE2},
    '{8'hE3, 8'hE3}, '{8'hA4, 8'hA4},
    '{8'hA5, 8'hA4}, '{8'h27, 8'h24},
    '{8'h98, 8'h98}, '{8'hA0, 8'hA0}};

  occ_oscillator_control #(.SYSFAIL_CYCLES(50), .WDTFAIL_CYCLES(40)) occ_oscillator_control_i (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .option_bits(option_bits),
    .sysclk_osc_in(sys_osc), .watchdog_osc_in(wdt_osc),
    .precision_osc_enable(precision_osc_enable), .crystal_osc_enable(crystal_osc_enable),
    .crystal_pin_override(crystal_pin_override), .watchdog_osc_enable(watchdog_osc_enable),
    .sysclk_source_select(sysclk_source_select), .crystal_drive_mode(crystal_drive_mode),
    .sysclk_fail_event(sysclk_fail_event), .watchdog_fail_event(watchdog_fail_event),
    .irq(irq));

  occ_osc_model occ_osc_model_i (
    .run_sys(run_sys), .run_wdt(run_wdt),
    .sysclk_osc_out(sys_osc), .watchdog_osc_out(wdt_osc));

  // The 40 MHz clock.
  initial ref_clk = 1'h0;
  always #12.5 ref_clk = ~ref_clk;

  // Counts cycles and event pulses, and cuts a hang short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (sysclk_fail_event === 1'h1) sys_ev <= sys_ev + 1;
    if (watchdog_fail_event === 1'h1) wdt_ev <= wdt_ev + 1;
    if (cyc == MAX_CYC) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t run took too long", $time);
      give_verdict();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Compares: %0d, mismatches: %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // Compares a seen value with the expected one.
  task automatic chk(logic [7:0] seen, logic [7:0] exp, string what);
    compares = compares + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t %s: seen %h, expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Waits a number of clock edges.
  task automatic tick(int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick

  // One write cycle, then one idle cycle so strobes never collide.
  task automatic wr(logic [11:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    @(posedge ref_clk);
  endtask : wr

  // One read cycle; the data are taken at the edge that closes the cycle after it.
  task automatic rd(logic [11:0] a);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(posedge ref_clk);
    rd_val = reg_rdata;
  endtask : rd

  // Unlocks the control register and writes a value.
  task automatic ctl_set(logic [7:0] d);
    wr(`OCC_CTL_ADDR, `OCC_UNLOCK_FIRST);
    wr(`OCC_CTL_ADDR, `OCC_UNLOCK_SECOND);
    wr(`OCC_CTL_ADDR, d);
    tick(2);
  endtask : ctl_set

  // Checks the control outputs and the read-back value.
  task automatic chk_ctl(logic [7:0] e);
    chk(precision_osc_enable, e[7], "precision enable");
    chk(crystal_osc_enable, e[6], "crystal enable");
    chk(crystal_pin_override, e[6], "pin override");
    chk(watchdog_osc_enable, e[5], "watchdog enable");
    chk(sysclk_source_select, e[2:0], "source select");
    rd(`OCC_CTL_ADDR);
    chk(rd_val, e, "control read-back");
  endtask : chk_ctl

  // Main sequence: reset, table of writes, then the awkward cases.
  initial begin
    reset = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    option_bits = 3'h6;
    run_sys = 1'h1;
    run_wdt = 1'h1;
    {err_total, compares, cyc, sys_ev, wdt_ev} = '0;
    tick(6);
    reset <= 1'h0;
    tick(1);
    rd(`OCC_CTL_ADDR);
    chk(rd_val, 8'hA0, "reset control");
    chk(crystal_drive_mode, 8'h2, "drive mode");
    rd(`OCC_STAT_ADDR);
    chk(rd_val, 8'h00, "reset status");
    rd(12'hF89);
    chk(rd_val, 8'h00, "unmapped read");
    // A second reset with the crystal option the other way.
    reset <= 1'h1;
    option_bits <= 3'h1;
    tick(2);
    reset <= 1'h0;
    tick(1);
    chk(crystal_drive_mode, 8'h1, "drive mode");
    chk_ctl(8'hE0);
    foreach (rows[i]) begin
      // Lets the crystal settle for more than 1000 of its cycles.
      if (rows[i].wdata[2:0] == `OCC_SEL_XTAL) tick(13000);
      ctl_set(rows[i].wdata);
      chk_ctl(rows[i].exp_ctl);
    end
    // Writes without unlock, or with the values out of order.
    wr(`OCC_CTL_ADDR, 8'hC4);
    wr(`OCC_CTL_ADDR, 8'h18);
    wr(`OCC_CTL_ADDR, 8'hE7);
    wr(`OCC_CTL_ADDR, 8'hC4);
    chk_ctl(8'hA0);
    // Unlock with other accesses in between, then relock.
    wr(`OCC_CTL_ADDR, 8'hE7);
    wr(`OCC_MASK_ADDR, 8'h00);
    rd(`OCC_STAT_ADDR);
    wr(`OCC_CTL_ADDR, 8'h18);
    wr(`OCC_CTL_ADDR, 8'hC4);
    wr(`OCC_CTL_ADDR, 8'hA0);
    chk_ctl(8'hC4);
    ctl_set(8'hA0);
    // System oscillator stops: no event while detection is off.
    run_sys <= 1'h0;
    tick(150);
    chk(8'(sys_ev), 8'h0, "event while off");
    ctl_set(8'hB0);
    n = 0;
    while (sys_ev == 0 && n < 300) begin
      tick(1);
      n++;
    end
    chk(8'(n >= 40 && n <= 62), 8'h1, "failure delay");
    tick(2);
    chk(8'(sys_ev), 8'h1, "one event pulse");
    chk(sysclk_source_select, 8'h3, "recovery select");
    chk(irq, 8'h0, "masked irq");
    rd(`OCC_STAT_ADDR);
    chk(rd_val, 8'h01, "clock failure status");
    wr(`OCC_MASK_ADDR, 8'h01);
    tick(1);
    chk(irq, 8'h1, "unmasked irq");
    wr(`OCC_STAT_ADDR, 8'h01);
    tick(1);
    chk(irq, 8'h0, "cleared irq");
    run_sys <= 1'h1;
    ctl_set(8'hA0);
    chk_ctl(8'hA0);
    // Watchdog oscillator stops: flagged only with detection on.
    run_wdt <= 1'h0;
    tick(100);
    chk(8'(wdt_ev), 8'h0, "watchdog event while off");
    ctl_set(8'hA8);
    n = 0;
    while (wdt_ev == 0 && n < 300) begin
      tick(1);
      n++;
    end
    chk(8'(n >= 30 && n <= 55), 8'h1, "watchdog failure delay");
    chk(sysclk_source_select, 8'h0, "no switch");
    rd(`OCC_STAT_ADDR);
    chk(rd_val, 8'h02, "watchdog failure status");
    give_verdict();
  end
endmodule : occ_oscillator_control_tb_top
`default_nettype wire
